// ---- inc/csf_defs.svh ----
// constants for the charger condition flags block
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH
// command codes
`define CSF_CMD_CONTROL 8'h12
`define CSF_CMD_STATUS 8'h13
`define CSF_CMD_VOLTAGE 8'h15
// status bit positions
`define CSF_BIT_DEPLETED 11
`define CSF_BIT_VOR 12
`define CSF_BIT_BAT_ABOVE 13
`define CSF_BIT_BAT_PRESENT 14
`define CSF_BIT_ADAPTER 15
// control fields
`define CSF_CTL_LEARN 4
`define CSF_CTL_DEP_LO 9
`define CSF_CTL_DEP_HI 11
// reset values
`define CSF_CONTROL_RST 16'h0000
`define CSF_VOLTAGE_RST 16'h0000
// voltage settings in mV
`define CSF_MV_WAKE 16'h2328
`define CSF_MV_3C_LO 16'h2ee0
`define CSF_MV_3C_HI 16'h3840
`define CSF_MV_4C_LO 16'h3e80
`define CSF_MV_4C_HI 16'h4b00
`define CSF_CV_STEP_MASK 16'hfff0
`define CSF_CELLS_3 16'h0003
`define CSF_CELLS_4 16'h0004
// per-cell depleted level: base plus code times step
`define CSF_DEP_BASE_MV 16'h0b54
`define CSF_DEP_STEP_MV 16'h0064
// timing
`define CSF_CLK_KHZ 50000
`define CSF_BYPASS_DEGLITCH_MS 8
`define CSF_ALERT_DELAY_MS 8
`define CSF_BYPASS_CYCLES (`CSF_BYPASS_DEGLITCH_MS * `CSF_CLK_KHZ)
`define CSF_ALERT_CYCLES (`CSF_ALERT_DELAY_MS * `CSF_CLK_KHZ)
`endif

// ---- inc/csf_pkg.sv ----
// types shared by the charger condition flags block
package csf_pkg;
  // comparator and converter results from the analog front end
  typedef struct packed {
    logic [15:0] bat_mv;
    logic adapter_above_trip;
    logic adapter_above_por;
    logic vcc_above_por;
    logic bat_above_adapter;
    logic input_near_bat;
    logic input_recovered;
    logic thermistor_low;
  } csf_sense_t;
  // register access handed over by the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } csf_reg_req_t;
  // switch, regulator and host-facing controls
  typedef struct packed {
    logic battery_switch_drive;
    logic adapter_switch_drive;
    logic input_bypass_switch;
    logic charge_enable;
    logic five_volt_reference;
    logic smbus_enable;
    logic alert;
    logic [15:0] vreg_mv;
  } csf_drive_t;
  // whole state of the top module
  typedef struct packed {
    logic [15:0] control;
    logic [15:0] voltage;
    logic [15:0] status;
    logic [15:0] rdata;
    csf_drive_t drv;
    logic alert_pending;
  } csf_state_t;
endpackage

// ---- rtl/csf_hold_timer.sv ----
// qualify timer: done rises once run has held for COUNT cycles
`timescale 1ns/100ps
module csf_hold_timer #(
  parameter int COUNT = 400000
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic run, // condition being qualified
  output logic done // high while qualified
);
  localparam int W = $clog2(COUNT + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } csf_tmr_state_t;

  csf_tmr_state_t st_r;
  csf_tmr_state_t st_nxt;

  ////////////////////////////////////////////////////////////////
  // any drop of run restarts the count, so glitches never qualify
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = '0;
      st_nxt.done = 1'b0;
    end else if (st_r.cnt == W'(COUNT - 1)) begin
      st_nxt.done = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + W'(1);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done = st_r.done;

  ////////////////////////////////////////////////////////////////
  done_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(done) |-> $past(run) && $past(st_r.cnt) == W'(COUNT - 1))
    else $error("timer done without full hold");
endmodule

// ---- rtl/csf_charger_flags.sv ----
// upper status flags and autonomous power-path control of the charger
`timescale 1ns/100ps
`include "csf_defs.svh"
module csf_charger_flags import csf_pkg::*; #(
  parameter int BYPASS_CYCLES = `CSF_BYPASS_CYCLES,
  parameter int ALERT_CYCLES = `CSF_ALERT_CYCLES
) (
  input wire logic clk, // 50 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire csf_sense_t sense, // comparator results
  input wire csf_reg_req_t req, // register access
  output logic [15:0] reg_rdata, // read data, registered
  output csf_drive_t drv // switch and regulator drives
);
  csf_state_t st_r;
  csf_state_t st_nxt;

  logic por_ok;
  logic [15:0] cv_trunc;
  logic cv_wake;
  logic cv_over;
  logic cv_3c;
  logic cv_4c;
  logic cv_bad;
  logic [15:0] cells;
  logic [15:0] per_cell_mv;
  logic [15:0] thr_mv;
  logic depleted;
  logic learn;
  logic adapter;
  logic battery_in;
  logic adapter_sw;
  logic bypass_run;
  logic bypass_done;
  logic alert_run;
  logic alert_done;
  logic toggle;
  logic status_rd;

  ////////////////////////////////////////////////////////////////
  // recovery qualifier for the bypass switch
  assign bypass_run = sense.input_recovered & ~sense.input_near_bat;

  csf_hold_timer #(
    .COUNT(BYPASS_CYCLES)
  ) u_bypass_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(bypass_run),
    .done(bypass_done)
  );

  // alert delay; dropping run on done restarts it for the next toggle
  assign alert_run = st_r.alert_pending & ~alert_done;

  csf_hold_timer #(
    .COUNT(ALERT_CYCLES)
  ) u_alert_timer (
    .clk(clk),
    .rst_n(rst_n),
    .run(alert_run),
    .done(alert_done)
  );

  ////////////////////////////////////////////////////////////////
  // settings decode and flag evaluation
  always_comb begin
    st_nxt = st_r;
    // supplies gate the whole register side
    por_ok = sense.adapter_above_por & sense.vcc_above_por;
    adapter = sense.adapter_above_trip;
    battery_in = sense.thermistor_low;
    learn = st_r.control[`CSF_CTL_LEARN];

    // truncate to the converter step so the battery is never overdriven
    cv_trunc = st_r.voltage & `CSF_CV_STEP_MASK;
    cv_wake = st_r.voltage == `CSF_MV_WAKE;
    cv_over = st_r.voltage > `CSF_MV_4C_HI;
    cv_3c = (cv_trunc >= `CSF_MV_3C_LO) && (cv_trunc <= `CSF_MV_3C_HI);
    cv_4c = (cv_trunc >= `CSF_MV_4C_LO) && (cv_trunc <= `CSF_MV_4C_HI);
    cv_bad = ~(cv_wake | cv_over | cv_3c | cv_4c);

    // depleted level scales with the cell count of the setting
    cells = (cv_4c | cv_over) ? `CSF_CELLS_4 : `CSF_CELLS_3;
    per_cell_mv = `CSF_DEP_BASE_MV + 16'(st_r.control[`CSF_CTL_DEP_HI:`CSF_CTL_DEP_LO] * `CSF_DEP_STEP_MV);
    thr_mv = 16'(per_cell_mv * cells);
    depleted = sense.bat_mv < thr_mv;

    // live flags; the lower bits belong to other logic and read zero
    st_nxt.status = 16'h0000;
    st_nxt.status[`CSF_BIT_DEPLETED] = depleted;
    st_nxt.status[`CSF_BIT_VOR] = cv_bad | cv_over;
    st_nxt.status[`CSF_BIT_BAT_ABOVE] = sense.bat_above_adapter;
    st_nxt.status[`CSF_BIT_BAT_PRESENT] = battery_in;
    st_nxt.status[`CSF_BIT_ADAPTER] = adapter;

    // host writes; status writes fall through and are dropped
    if (!por_ok) begin
      st_nxt.control = `CSF_CONTROL_RST;
      st_nxt.voltage = `CSF_VOLTAGE_RST;
    end else if (req.wr) begin
      case (req.cmd)
        `CSF_CMD_CONTROL: begin
          st_nxt.control = req.wdata;
        end
        `CSF_CMD_VOLTAGE: begin
          st_nxt.voltage = req.wdata;
        end
        default: begin
        end
      endcase
    end

    // host reads; nothing answers while the supplies are low
    status_rd = por_ok & req.rd & (req.cmd == `CSF_CMD_STATUS);
    if (por_ok && req.rd) begin
      case (req.cmd)
        `CSF_CMD_CONTROL: begin
          st_nxt.rdata = st_r.control;
        end
        `CSF_CMD_STATUS: begin
          st_nxt.rdata = st_r.status;
        end
        `CSF_CMD_VOLTAGE: begin
          st_nxt.rdata = st_r.voltage;
        end
        default: begin
          st_nxt.rdata = 16'h0000;
        end
      endcase
    end

    // regulation target: wake-up level, clamp, nothing, or the truncated setting
    if (cv_wake) begin
      st_nxt.drv.vreg_mv = `CSF_MV_WAKE;
    end else if (cv_over) begin
      st_nxt.drv.vreg_mv = `CSF_MV_4C_HI;
    end else if (cv_bad) begin
      st_nxt.drv.vreg_mv = 16'h0000;
    end else begin
      st_nxt.drv.vreg_mv = cv_trunc;
    end

    // power path: adapter feeds system unless learning, or once depleted
    adapter_sw = adapter & (~learn | depleted);
    st_nxt.drv.adapter_switch_drive = adapter_sw;
    st_nxt.drv.battery_switch_drive = ~depleted & ~adapter_sw;

    // charge needs adapter, battery and a valid or clamped over-range setting
    st_nxt.drv.charge_enable = por_ok & adapter & battery_in & ~cv_bad;
    st_nxt.drv.five_volt_reference = adapter;
    st_nxt.drv.smbus_enable = por_ok;

    // bypass: cut without filtering, restore only after qualification
    if (sense.input_near_bat) begin
      st_nxt.drv.input_bypass_switch = 1'b0;
    end else if (bypass_done) begin
      st_nxt.drv.input_bypass_switch = 1'b1;
    end

    // any flag toggle with supplies good arms the alert; a new toggle wins over the fire
    toggle = por_ok & (st_nxt.status != st_r.status);
    st_nxt.alert_pending = toggle | (st_r.alert_pending & ~alert_done);
    // firing wins over a status read that clears it
    if (alert_done) begin
      st_nxt.drv.alert = 1'b1;
    end else if (status_rd) begin
      st_nxt.drv.alert = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register; outputs come straight from it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign drv = st_r.drv;

  ////////////////////////////////////////////////////////////////
  // checks on the flags and the autonomous actions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  depleted_flag_a: assert property (
    $past(rst_n) |-> st_r.status[`CSF_BIT_DEPLETED] == ($past(sense.bat_mv) < $past(thr_mv)))
    else $error("depleted flag missing");

  // code zero with a three-cell setting trips below three base levels
  dep_scale_a: assert property (
    $past(cv_3c && st_r.control[`CSF_CTL_DEP_HI:`CSF_CTL_DEP_LO] == 3'h0
      && sense.bat_mv >= 16'(`CSF_DEP_BASE_MV * `CSF_CELLS_3))
    |-> !st_r.status[`CSF_BIT_DEPLETED])
    else $error("depleted level not scaled by cells");

  bat_cut_a: assert property (
    st_r.status[`CSF_BIT_DEPLETED] |-> !drv.battery_switch_drive)
    else $error("battery switch on while depleted");

  learn_swap_a: assert property (
    st_r.status[`CSF_BIT_DEPLETED] && st_r.status[`CSF_BIT_ADAPTER]
    |-> drv.adapter_switch_drive)
    else $error("adapter switch not taken over");

  vor_block_a: assert property (
    st_r.status[`CSF_BIT_VOR] && drv.vreg_mv != `CSF_MV_4C_HI |-> !drv.charge_enable && drv.vreg_mv == 16'h0000)
    else $error("charging with invalid setting");

  clamp_max_a: assert property (
    $past(st_r.voltage) > `CSF_MV_4C_HI
    |-> drv.vreg_mv == `CSF_MV_4C_HI && st_r.status[`CSF_BIT_VOR])
    else $error("over-range setting not clamped");

  wake_level_a: assert property (
    $past(st_r.voltage) == `CSF_MV_WAKE
    |-> drv.vreg_mv == `CSF_MV_WAKE && !st_r.status[`CSF_BIT_VOR])
    else $error("wake-up setting mishandled");

  gap_range_a: assert property (
    $past(st_r.voltage) > `CSF_MV_3C_HI + 16'h000f && $past(st_r.voltage) < `CSF_MV_4C_LO
    |-> st_r.status[`CSF_BIT_VOR])
    else $error("gap setting not flagged");

  bat_above_a: assert property (
    $past(rst_n) |-> st_r.status[`CSF_BIT_BAT_ABOVE] == $past(sense.bat_above_adapter))
    else $error("battery-above flag wrong");

  bypass_cut_a: assert property (
    $past(sense.input_near_bat) |-> !drv.input_bypass_switch)
    else $error("bypass not cut at once");

  bypass_hold_a: assert property (
    $rose(drv.input_bypass_switch) |-> $past(bypass_done) && $past(bypass_run, 2))
    else $error("bypass restored without deglitch");

  bat_present_a: assert property (
    $past(rst_n) |-> st_r.status[`CSF_BIT_BAT_PRESENT] == $past(sense.thermistor_low))
    else $error("battery present flag wrong");

  no_battery_a: assert property (
    !st_r.status[`CSF_BIT_BAT_PRESENT] |-> !drv.charge_enable)
    else $error("charging without battery");

  adapter_flag_a: assert property (
    $past(rst_n) |-> st_r.status[`CSF_BIT_ADAPTER] == $past(sense.adapter_above_trip))
    else $error("adapter flag missing");

  adapter_gate_a: assert property (
    !st_r.status[`CSF_BIT_ADAPTER] |-> !drv.charge_enable && !drv.five_volt_reference)
    else $error("charge or reference without adapter");

  por_hold_a: assert property (
    !$past(por_ok) |-> !drv.smbus_enable && st_r.control == `CSF_CONTROL_RST)
    else $error("access open before supplies good");

  alert_rise_a: assert property (
    $rose(drv.alert) |-> $past(alert_done))
    else $error("alert without delay");

  status_read_a: assert property (
    $past(status_rd) |-> reg_rdata == $past(st_r.status))
    else $error("status read data wrong");
endmodule

// ---- dv/csf_host_model.sv ----
// host model issuing one-cycle register strobes
`timescale 1ns/100ps
module csf_host_model import csf_pkg::*; (
  input wire logic clk, // system clock
  input wire logic [15:0] rdata, // read data from block
  output csf_reg_req_t req // register access to block
);
  initial begin
    req = '0;
  end
  // strobe held one cycle, then select and data show inverted junk
  task automatic write(input logic [7:0] cmd, input logic [15:0] data);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, cmd: cmd, wdata: data};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: ~data};
  endtask
  // data is taken one edge after the read edge
  task automatic read(input logic [7:0] cmd, output logic [15:0] data);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, cmd: cmd, wdata: 16'h0000};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, cmd: ~cmd, wdata: 16'hffff};
    @(negedge clk);
    data = rdata;
  endtask
endmodule

// ---- dv/csf_charger_flags_tb.sv ----
// self-checking bench for the charger condition flags block
`timescale 1ns/100ps
module csf_charger_flags_tb import csf_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  csf_sense_t sense;
  csf_reg_req_t req;
  logic [15:0] reg_rdata;
  csf_drive_t drv;
  int num_errors = 0;
  int comparisons = 0;
  logic [15:0] rd;
  ////////////////////////////////////////////////////////////////
  // short counts keep the run brief
  localparam int BYPASS_N = 8;
  localparam int ALERT_N = 8;
  csf_charger_flags #(.BYPASS_CYCLES(BYPASS_N), .ALERT_CYCLES(ALERT_N)) csf_charger_flags_inst (
    .clk(clk), .rst_n(rst_n), .sense(sense), .req(req), .reg_rdata(reg_rdata), .drv(drv));
  csf_host_model csf_host_model_inst (.clk(clk), .rdata(reg_rdata), .req(req));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic close_out();
    $display("counts: %0d compared, %0d mismatched", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wait_n(2);
    cmp_word(drv.vreg_mv, 16'h0000);
    cmp_bit(drv.smbus_enable, 1'b0);
    cmp_bit(drv.charge_enable, 1'b0);
    rst_n = 1'b1;
    wait_n(3);
    cmp_bit(drv.smbus_enable, 1'b1);
    $display("test reset done");
  endtask
  // settings table: valid, wake-up, truncated, over-range, invalid
  task automatic t_voltage();
    logic [15:0] set_v [7] = '{16'h3840, 16'h2328, 16'h2ee7, 16'h4e20, 16'h3a98, 16'h2710, 16'h2329};
    logic [15:0] vreg_v [7] = '{16'h3840, 16'h2328, 16'h2ee0, 16'h4b00, 16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 7; i++) begin
      csf_host_model_inst.write(8'h15, set_v[i]);
      wait_n(2);
      csf_host_model_inst.read(8'h13, rd);
      cmp_bit(drv.charge_enable, i < 4);
      cmp_word(drv.vreg_mv, vreg_v[i]);
      cmp_bit(rd[12], i > 2);
    end
    $display("test voltage done");
  endtask
  // threshold edges with 3 and 4 cells, learn bit on and off
  task automatic t_depleted();
    logic [15:0] ctl [5] = '{16'h0000, 16'h0010, 16'h0010, 16'h0e00, 16'h0e00};
    logic [15:0] volt [5] = '{16'h3840, 16'h3840, 16'h3840, 16'h4b00, 16'h4b00};
    logic [15:0] battery_sense_pin [5] = '{16'h21fb, 16'h21fc, 16'h21fb, 16'h383f, 16'h3840};
    logic [2:0] exp_v [5] = '{3'b101, 3'b010, 3'b101, 3'b101, 3'b001};
    for (int i = 0; i < 5; i++) begin
      sense.bat_mv <= battery_sense_pin[i];
      csf_host_model_inst.write(8'h12, ctl[i]);
      csf_host_model_inst.write(8'h15, volt[i]);
      wait_n(2);
      csf_host_model_inst.read(8'h13, rd);
      cmp_bit(rd[11], exp_v[i][2]);
      cmp_bit(drv.battery_switch_drive, exp_v[i][1]);
      cmp_bit(drv.adapter_switch_drive, exp_v[i][0]);
    end
    sense.bat_mv <= 16'h3000;
    $display("test depleted done");
  endtask
  task automatic t_flags();
    csf_host_model_inst.write(8'h15, 16'h3840);
    wait_n(2);
    csf_host_model_inst.read(8'h13, rd);
    cmp_word(rd, 16'hc000);
    sense.bat_above_adapter <= 1'b1;
    csf_host_model_inst.write(8'h13, 16'h0000);
    csf_host_model_inst.read(8'h13, rd);
    cmp_word(rd, 16'he000);
    // a status write must not spill into the voltage setting
    csf_host_model_inst.read(8'h15, rd);
    cmp_word(rd, 16'h3840);
    csf_host_model_inst.read(8'h20, rd);
    cmp_word(rd, 16'h0000);
    sense.bat_above_adapter <= 1'b0;
    sense.thermistor_low <= 1'b0;
    wait_n(1);
    cmp_bit(drv.charge_enable, 1'b0);
    csf_host_model_inst.read(8'h13, rd);
    cmp_word(rd, 16'h8000);
    sense.thermistor_low <= 1'b1;
    sense.adapter_above_trip <= 1'b0;
    wait_n(1);
    cmp_bit(drv.charge_enable, 1'b0);
    cmp_bit(drv.five_volt_reference, 1'b0);
    csf_host_model_inst.read(8'h13, rd);
    cmp_word(rd, 16'h4000);
    sense.adapter_above_trip <= 1'b1;
    wait_n(1);
    cmp_bit(drv.five_volt_reference, 1'b1);
    $display("test flags done");
  endtask
  task automatic t_bypass();
    cmp_bit(drv.input_bypass_switch, 1'b1);
    sense.input_near_bat <= 1'b1;
    sense.input_recovered <= 1'b0;
    wait_n(1);
    cmp_bit(drv.input_bypass_switch, 1'b0);
    sense.input_near_bat <= 1'b0;
    sense.input_recovered <= 1'b1;
    // restore lands on the edge after the full qualify count, not earlier
    wait_n(BYPASS_N);
    cmp_bit(drv.input_bypass_switch, 1'b0);
    wait_n(1);
    cmp_bit(drv.input_bypass_switch, 1'b1);
    $display("test bypass done");
  endtask
  // alert follows a toggle after the delay and a status read clears it
  task automatic t_alert();
    wait_n(20);
    csf_host_model_inst.read(8'h13, rd);
    cmp_bit(drv.alert, 1'b0);
    sense.bat_above_adapter <= 1'b1;
    // pending arms one edge after the flag, then the full delay count runs
    wait_n(ALERT_N);
    cmp_bit(drv.alert, 1'b0);
    wait_n(2);
    cmp_bit(drv.alert, 1'b1);
    csf_host_model_inst.read(8'h13, rd);
    cmp_bit(drv.alert, 1'b0);
    $display("test alert done");
  endtask
  // access with supplies low is ignored and serial access withheld
  task automatic t_por();
    sense.vcc_above_por <= 1'b0;
    wait_n(2);
    cmp_bit(drv.smbus_enable, 1'b0);
    csf_host_model_inst.write(8'h15, 16'h3840);
    sense.vcc_above_por <= 1'b1;
    wait_n(2);
    cmp_bit(drv.smbus_enable, 1'b1);
    csf_host_model_inst.read(8'h15, rd);
    cmp_word(rd, 16'h0000);
    // the adapter-side supply gates access just as the main supply does
    sense.adapter_above_por <= 1'b0;
    wait_n(2);
    cmp_bit(drv.smbus_enable, 1'b0);
    sense.adapter_above_por <= 1'b1;
    wait_n(2);
    cmp_bit(drv.smbus_enable, 1'b1);
    $display("test por done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    sense = '{bat_mv: 16'h3000, adapter_above_trip: 1'b1, adapter_above_por: 1'b1, vcc_above_por: 1'b1,
      bat_above_adapter: 1'b0, input_near_bat: 1'b0, input_recovered: 1'b1, thermistor_low: 1'b1};
    t_reset();
    t_voltage();
    t_depleted();
    t_flags();
    t_bypass();
    t_alert();
    t_por();
    close_out();
  end
  // watchdog well past the expected length of the tests
  initial begin
    #200us;
    num_errors++;
    close_out();
  end
endmodule
